// file: bench/testbench.sv
/* self-checking bench: axi4-lite software side plus a two-wire master receiver.
   assumes pull-ups on both bus lines and a 25 ns system clock. */
`timescale 1ns/10ps
module testbench
   import tws_pkg::*;
;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic rready = 0, sleep_deep = 0, arb_lost = 0, awready, wready, bvalid, arready;
   logic rvalid, scl_o, scl_oe, sda_o, sda_oe, wake_req, rx_select, start_go;
   logic m_scl_oe, m_sda_oe, ak;
   logic [7:0] awaddr = 0, araddr = 0, d, rx;
   logic [31:0] wdata = 0, rdata;
   logic [1:0] bresp, rresp, r;
   int n_mismatch = 0, num_checks = 0, n_go = 0, n_rx = 0;
   wire scl = !((scl_oe & !scl_o) | m_scl_oe);
   wire sda = !((sda_oe & !sda_o) | m_sda_oe);
   always #12.5 aclk = !aclk;
   tws_slave_tx tws_slave_tx_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .sleep_deep(sleep_deep), .arb_lost_addr(arb_lost), .wake_req(wake_req),
      .rx_select(rx_select), .start_go(start_go));
   tws_master_model tws_master_model_inst (.scl(scl), .sda(sda), .scl_oe(m_scl_oe),
      .sda_oe(m_sda_oe));
   // one-cycle pulses are counted where they stand
   always @(posedge aclk)
   begin
      if (start_go === 1'b1) n_go++;
      if (rx_select === 1'b1) n_rx++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // bounded wait, sampled mid-cycle so the next rising edge is the taking one
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      @(negedge aclk);
      while (s !== 1'b1 && n < 200)
      begin
         @(negedge aclk);
         n++;
      end
      if (n == 200) n_mismatch++;
   endtask : wait_hi
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic da, dw;
      da = 0;
      dw = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // each channel released at its own handshake edge
      while (!(da && dw))
      begin
         @(negedge aclk);
         da = da | awready;
         dw = dw | wready;
         @(posedge aclk);
         if (da) awvalid <= 1'b0;
         if (dw) wvalid <= 1'b0;
      end
      wait_hi(bvalid);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      wait_hi(arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      wait_hi(rvalid);
      d = rdata[7:0];
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask : rd
   // wait for the job-done flag, then compare the state report
   task automatic poll(input logic [7:0] st);
      for (int i = 0; i < 60; i++)
      begin
         rd(TWS_OFS_CTRL);
         if (d[TWS_CTRL_JOB_DONE] === 1'b1) break;
      end
      rd(TWS_OFS_STATUS);
      chk(d, st);
   endtask : poll
   task automatic t_regs;
      rd(TWS_OFS_STATUS);
      chk(d, 8'hf8);
      rd(TWS_OFS_DATA);
      chk(d, 8'hff);
      rd(8'h10);
      chk(r, TWS_RESP_SLVERR);
      wr(8'h14, 8'h00);
      chk(r, TWS_RESP_SLVERR);
      wr(TWS_OFS_ADDR_CFG, 8'h55);
      wr(TWS_OFS_CTRL, 8'h44);
      rd(TWS_OFS_ADDR_CFG);
      chk(d, 8'h55);
   endtask : t_regs
   // lost arbitration entry, nack ending, start request, then isolation
   task automatic t_arb_nack;
      @(posedge aclk) arb_lost <= 1'b1;
      @(posedge aclk) arb_lost <= 1'b0;
      tws_master_model_inst.start_cond();
      tws_master_model_inst.xfer(8'h55, 1'b1, rx, ak);
      chk(ak, 1'b0);
      poll(TWS_ST_ARB_READ);
      wr(TWS_OFS_DATA, 8'h96);
      wr(TWS_OFS_CTRL, 8'hc4);
      tws_master_model_inst.xfer(8'hff, 1'b1, rx, ak);
      chk(rx, 8'h96);
      poll(TWS_ST_DATA_NACK);
      wr(TWS_OFS_CTRL, 8'ha4);
      tws_master_model_inst.stop_cond();
      chk(n_go, 1);
      tws_master_model_inst.start_cond();
      tws_master_model_inst.xfer(8'h55, 1'b1, rx, ak);
      chk(ak, 1'b1);
      tws_master_model_inst.stop_cond();
   endtask : t_arb_nack
   // resumed recognition in deep sleep, acked bytes, early last byte, ignored extra
   task automatic t_main;
      wr(TWS_OFS_CTRL, 8'h44);
      sleep_deep <= 1'b1;
      tws_master_model_inst.start_cond();
      tws_master_model_inst.xfer(8'h55, 1'b1, rx, ak);
      chk(ak, 1'b0);
      poll(TWS_ST_OWN_READ);
      chk(wake_req, 1'b1);
      sleep_deep <= 1'b0;
      wr(TWS_OFS_DATA, 8'h3c);
      wr(TWS_OFS_CTRL, 8'hc4);
      tws_master_model_inst.xfer(8'hff, 1'b0, rx, ak);
      chk(rx, 8'h3c);
      poll(TWS_ST_DATA_ACK);
      wr(TWS_OFS_DATA, 8'ha5);
      wr(TWS_OFS_CTRL, 8'h84);
      tws_master_model_inst.xfer(8'hff, 1'b0, rx, ak);
      chk(rx, 8'ha5);
      poll(TWS_ST_LAST_ACK);
      wr(TWS_OFS_CTRL, 8'hc4);
      tws_master_model_inst.xfer(8'hff, 1'b0, rx, ak);
      chk(rx, 8'hff);
      tws_master_model_inst.stop_cond();
   endtask : t_main
   // general call with read bit and own write address are not acked here
   task automatic t_refuse;
      wr(TWS_OFS_CTRL, 8'h44);
      tws_master_model_inst.start_cond();
      tws_master_model_inst.xfer(8'h01, 1'b1, rx, ak);
      chk(ak, 1'b1);
      tws_master_model_inst.stop_cond();
      tws_master_model_inst.start_cond();
      tws_master_model_inst.xfer(8'h54, 1'b1, rx, ak);
      tws_master_model_inst.stop_cond();
      chk({ak, n_rx[0]}, 2'h3);
   endtask : t_refuse
   task automatic give_verdict;
      if (n_mismatch == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict
   // reset, then the scenarios in order
   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_arb_nack();
      t_main();
      t_refuse();
      give_verdict();
   end
   // watchdog well beyond the expected few tens of microseconds
   initial
   begin
      #2000000;
      n_mismatch++;
      give_verdict();
   end
endmodule : testbench

// file: bench/tws_master_model.sv
/* two-wire master receiver model pulling scl and sda through open-drain enables.
   assumes the bench resolves both lines with pull-ups. */
`timescale 1ns/10ps
module tws_master_model
(
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_oe,
   output logic      sda_oe
);
   // both lines released until the first frame
   initial
   begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // one clock; data moves only with scl low, a stretched low is waited out
   task automatic bit_io(input logic d, output logic q);
      sda_oe = !d;
      #50;
      scl_oe = 1'b0;
      repeat (8000) if (!scl) #25;
      #100;
      q = sda;
      scl_oe = 1'b1;
      #50;
   endtask : bit_io
   // start: sda falls while scl is high
   task automatic start_cond;
      sda_oe = 1'b1;
      #100;
      scl_oe = 1'b1;
      #50;
   endtask : start_cond
   // stop: sda rises while scl is high, then the bus idles
   task automatic stop_cond;
      sda_oe = 1'b1;
      #50;
      scl_oe = 1'b0;
      #100;
      sda_oe = 1'b0;
      #200;
   endtask : stop_cond
   // eight bits msb first, then the ninth clock with the given acknowledge
   task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                       output logic aq);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ak, aq);
   endtask : xfer
endmodule : tws_master_model

// file: include/tws_pkg.sv
/*
 * constants, register map and state type for the two-wire slave transmitter.
 * assumes a 32-bit axi4-lite register bus; all registers are 8 bits in the low byte.
 */
package tws_pkg;
   // register byte offsets
   localparam logic [7:0] TWS_OFS_ADDR_CFG = 8'h00;
   localparam logic [7:0] TWS_OFS_CTRL     = 8'h04;
   localparam logic [7:0] TWS_OFS_STATUS   = 8'h08;
   localparam logic [7:0] TWS_OFS_DATA     = 8'h0c;
   // register select codes from the address decoder
   localparam logic [2:0] TWS_SEL_ADDR_CFG = 3'h0;
   localparam logic [2:0] TWS_SEL_CTRL     = 3'h1;
   localparam logic [2:0] TWS_SEL_STATUS   = 3'h2;
   localparam logic [2:0] TWS_SEL_DATA     = 3'h3;
   localparam logic [2:0] TWS_SEL_NONE     = 3'h7;
   // serial_control field positions
   localparam int TWS_CTRL_JOB_DONE  = 7;
   localparam int TWS_CTRL_ACK_EN    = 6;
   localparam int TWS_CTRL_START_REQ = 5;
   localparam int TWS_CTRL_STOP_REQ  = 4;
   localparam int TWS_CTRL_WCOL      = 3;
   localparam int TWS_CTRL_IF_EN     = 2;
   localparam int TWS_CTRL_IRQ_EN    = 0;
   // slave_address_config field positions
   localparam int TWS_ADDR_GCE       = 0;
   // reset values
   localparam logic [7:0] TWS_ADDR_CFG_RST = 8'h00;
   localparam logic [7:0] TWS_DATA_RST     = 8'hff;
   localparam logic       TWS_ACK_RST      = 1'b0;
   // status codes, prescaler bits always zero
   localparam logic [7:0] TWS_ST_OWN_READ  = 8'ha8;
   localparam logic [7:0] TWS_ST_ARB_READ  = 8'hb0;
   localparam logic [7:0] TWS_ST_DATA_ACK  = 8'hb8;
   localparam logic [7:0] TWS_ST_DATA_NACK = 8'hc0;
   localparam logic [7:0] TWS_ST_LAST_ACK  = 8'hc8;
   localparam logic [7:0] TWS_ST_NO_INFO   = 8'hf8;
   localparam logic [6:0] TWS_BROADCAST    = 7'h00;
   localparam logic [2:0] TWS_LAST_BIT     = 3'h7;
   // axi responses
   localparam logic [1:0] TWS_RESP_OKAY    = 2'h0;
   localparam logic [1:0] TWS_RESP_SLVERR  = 2'h2;

   typedef enum logic [2:0]
   {
      TWS_IDLE     = 3'b000,
      TWS_ADDR     = 3'b001,
      TWS_ADDR_ACK = 3'b010,
      TWS_TX_LOAD  = 3'b011,
      TWS_TX_BYTE  = 3'b100,
      TWS_TX_ACK   = 3'b101,
      TWS_DONE     = 3'b110,
      TWS_IGNORE   = 3'b111
   } tws_state_t;
endpackage : tws_pkg

// file: rtl/tws_slave_tx.sv
/*
 * two-wire slave transmitter with an axi4-lite register port.
 * assumes scl/sda arrive asynchronously and are resolved open-drain outside;
 * sleep_deep and arb_lost_addr come from logic on aclk.
 */
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module tws_slave_tx
   import tws_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic        sleep_deep,
   input  wire logic        arb_lost_addr,
   output logic             wake_req,
   output logic             rx_select,
   output logic             start_go
);

   // address decode shared by read and write paths
   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      case (a)
         TWS_OFS_ADDR_CFG: reg_sel = TWS_SEL_ADDR_CFG;
         TWS_OFS_CTRL:     reg_sel = TWS_SEL_CTRL;
         TWS_OFS_STATUS:   reg_sel = TWS_SEL_STATUS;
         TWS_OFS_DATA:     reg_sel = TWS_SEL_DATA;
         default:          reg_sel = TWS_SEL_NONE;
      endcase
   endfunction : reg_sel

   tws_state_t  st_ff;
   logic [7:0]  addr_cfg_ff;
   logic [7:0]  data_ff;
   logic [7:0]  shift_ff;
   logic [7:0]  code_ff;
   logic [2:0]  bitcnt_ff;
   logic        flag_ff;
   logic        ack_en_ff;
   logic        start_req_ff;
   logic        stop_req_ff;
   logic        if_en_ff;
   logic        irq_en_ff;
   logic        wcol_ff;
   logic        last_ff;
   logic        ack_seen_ff;
   logic        arb_ff;
   logic        busy_ff;
   logic        start_pend_ff;
   logic        wake_ff;
   logic        rx_sel_ff;
   logic        start_go_ff;
   logic        scl_m_ff;
   logic        scl_s_ff;
   logic        scl_d_ff;
   logic        sda_m_ff;
   logic        sda_s_ff;
   logic        sda_d_ff;
   logic        aw_hold_ff;
   logic        w_hold_ff;
   logic [7:0]  awaddr_ff;
   logic [7:0]  wdata_ff;
   logic        wstrb0_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_cond;
   logic        stop_cond;
   logic        do_wr;
   logic        wr_ctrl;
   logic        wr_data;
   logic        go;
   logic        flag_set;
   logic [7:0]  nxt_code;
   logic [7:0]  addr_byte;
   logic        own_hit;
   logic        gc_hit;
   logic        addr_hit;
   logic        read_hit;
   logic [2:0]  wsel;
   logic [7:0]  status_rd;

   // two-stage synchronisers; edge logic reads only the second stage and its delay
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {scl_m_ff, scl_s_ff, scl_d_ff} <= 3'h7;
         {sda_m_ff, sda_s_ff, sda_d_ff} <= 3'h7;
      end
      else
      begin
         {scl_m_ff, scl_s_ff, scl_d_ff} <= {scl_i, scl_m_ff, scl_s_ff};
         {sda_m_ff, sda_s_ff, sda_d_ff} <= {sda_i, sda_m_ff, sda_s_ff};
      end
   end

   // bus events; start/stop need scl steady high across the sda edge
   assign scl_rise   = scl_s_ff & ~scl_d_ff;
   assign scl_fall   = ~scl_s_ff & scl_d_ff;
   assign start_cond = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
   assign stop_cond  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

   // address compare on the eighth bit as it arrives
   assign addr_byte = {shift_ff[6:0], sda_s_ff};
   assign own_hit   = addr_byte[7:1] == addr_cfg_ff[7:1];
   assign gc_hit    = (addr_byte[7:1] == TWS_BROADCAST) & addr_cfg_ff[TWS_ADDR_GCE];
   // ack enable gates recognition live, so clearing it isolates the device
   assign addr_hit  = ack_en_ff & (own_hit | gc_hit);
   assign read_hit  = addr_hit & own_hit & addr_byte[0];

   // axi write side: channels captured independently, committed together
   assign wsel    = reg_sel(awaddr_ff);
   assign do_wr   = aw_hold_ff & w_hold_ff & ~bvalid_ff;
   assign wr_ctrl = do_wr & wstrb0_ff & (wsel == TWS_SEL_CTRL);
   assign wr_data = do_wr & wstrb0_ff & (wsel == TWS_SEL_DATA);
   assign go      = flag_ff & wr_ctrl & wdata_ff[TWS_CTRL_JOB_DONE];

   // flag events: ninth falling edge of the address or of a data byte
   always_comb
   begin
      flag_set = 1'b0;
      nxt_code = code_ff;
      if (scl_fall && st_ff == TWS_ADDR_ACK && bitcnt_ff != 3'h0)
      begin
         flag_set = 1'b1;
         nxt_code = arb_ff ? TWS_ST_ARB_READ : TWS_ST_OWN_READ;
      end
      else if (scl_fall && st_ff == TWS_TX_ACK)
      begin
         flag_set = 1'b1;
         if (!ack_seen_ff)
            nxt_code = TWS_ST_DATA_NACK;
         else if (last_ff)
            nxt_code = TWS_ST_LAST_ACK;
         else
            nxt_code = TWS_ST_DATA_ACK;
      end
   end

   // transfer state machine
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !if_en_ff)
      begin
         st_ff       <= TWS_IDLE;
         bitcnt_ff   <= 3'h0;
         shift_ff    <= 8'h00;
         last_ff     <= 1'b0;
         ack_seen_ff <= 1'b0;
      end
      else if ((start_cond || stop_cond) && st_ff != TWS_TX_LOAD && st_ff != TWS_DONE)
      begin
         st_ff     <= start_cond ? TWS_ADDR : TWS_IDLE;
         bitcnt_ff <= 3'h0;
      end
      else
      begin
         case (st_ff)
            TWS_ADDR:
               if (scl_rise)
               begin
                  shift_ff  <= addr_byte;
                  bitcnt_ff <= bitcnt_ff + 3'h1;
                  if (bitcnt_ff == TWS_LAST_BIT)
                     st_ff <= read_hit ? TWS_ADDR_ACK : TWS_IGNORE;
               end
            TWS_ADDR_ACK:
               if (scl_fall)
               begin
                  bitcnt_ff <= 3'h1;
                  if (bitcnt_ff != 3'h0)
                     st_ff <= TWS_TX_LOAD;
               end
            TWS_TX_LOAD:
               if (go)
               begin
                  shift_ff  <= data_ff;
                  last_ff   <= ~wdata_ff[TWS_CTRL_ACK_EN];
                  bitcnt_ff <= 3'h0;
                  st_ff     <= TWS_TX_BYTE;
               end
            TWS_TX_BYTE:
               if (scl_fall)
               begin
                  // next bit only after scl has gone low
                  shift_ff  <= {shift_ff[6:0], 1'b1};
                  bitcnt_ff <= bitcnt_ff + 3'h1;
                  if (bitcnt_ff == TWS_LAST_BIT)
                     st_ff <= TWS_TX_ACK;
               end
            TWS_TX_ACK:
            begin
               if (scl_rise)
                  ack_seen_ff <= ~sda_s_ff;
               if (scl_fall)
                  st_ff <= (ack_seen_ff && !last_ff) ? TWS_TX_LOAD : TWS_DONE;
            end
            TWS_DONE:
               if (go)
                  st_ff <= TWS_IGNORE;
            default:
               st_ff <= st_ff;
         endcase
      end
   end

   // job-done flag and status; a hardware set beats a software clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !if_en_ff)
      begin
         flag_ff <= 1'b0;
         code_ff <= TWS_ST_NO_INFO;
      end
      else if (flag_set)
      begin
         flag_ff <= 1'b1;
         code_ff <= nxt_code;
      end
      else if (go)
         flag_ff <= 1'b0;
   end

   // status reads f8 whenever the flag is clear
   assign status_rd = flag_ff ? code_ff : TWS_ST_NO_INFO;

   // arbitration loss marker, kept through the address ack so the ninth fall still sees it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         arb_ff <= 1'b0;
      else if (arb_lost_addr)
         arb_ff <= 1'b1;
      else if (flag_set || (st_ff == TWS_ADDR && scl_rise && bitcnt_ff == TWS_LAST_BIT
                            && !read_hit))
         arb_ff <= 1'b0;
   end

   // bus busy tracking and deferred start request
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         busy_ff       <= 1'b0;
         start_pend_ff <= 1'b0;
         start_go_ff   <= 1'b0;
      end
      else
      begin
         if (start_cond)
            busy_ff <= 1'b1;
         else if (stop_cond)
            busy_ff <= 1'b0;
         start_go_ff <= start_pend_ff & ~busy_ff;
         if (st_ff == TWS_DONE && go && wdata_ff[TWS_CTRL_START_REQ])
            start_pend_ff <= 1'b1;
         else if (!busy_ff)
            start_pend_ff <= 1'b0;
      end
   end

   // wake-up request held while asleep, receiver hand-off pulse
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wake_ff   <= 1'b0;
         rx_sel_ff <= 1'b0;
      end
      else
      begin
         rx_sel_ff <= st_ff == TWS_ADDR && scl_rise && bitcnt_ff == TWS_LAST_BIT
                      && addr_hit && !addr_byte[0];
         // sampled bus clock stands in for the bus-clocked matcher while asleep
         if (sleep_deep && st_ff == TWS_ADDR_ACK)
            wake_ff <= 1'b1;
         else if (!sleep_deep)
            wake_ff <= 1'b0;
      end
   end

   // open-drain drive; sda only moves while scl is low because shifting follows scl_fall
   assign scl_o  = 1'b0;
   assign sda_o  = 1'b0;
   assign scl_oe = flag_ff;
   assign sda_oe = (st_ff == TWS_ADDR_ACK && bitcnt_ff != 3'h0)
                   | (st_ff == TWS_TX_BYTE && !shift_ff[7]);

   // control and address registers; software-written fields only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         addr_cfg_ff  <= TWS_ADDR_CFG_RST;
         ack_en_ff    <= TWS_ACK_RST;
         start_req_ff <= 1'b0;
         stop_req_ff  <= 1'b0;
         if_en_ff     <= 1'b0;
         irq_en_ff    <= 1'b0;
      end
      else
      begin
         if (do_wr && wstrb0_ff && wsel == TWS_SEL_ADDR_CFG)
            addr_cfg_ff <= wdata_ff;
         if (wr_ctrl)
         begin
            ack_en_ff    <= wdata_ff[TWS_CTRL_ACK_EN];
            start_req_ff <= wdata_ff[TWS_CTRL_START_REQ];
            stop_req_ff  <= wdata_ff[TWS_CTRL_STOP_REQ];
            if_en_ff     <= wdata_ff[TWS_CTRL_IF_EN];
            irq_en_ff    <= wdata_ff[TWS_CTRL_IRQ_EN];
         end
      end
   end

   // data register holds only what software wrote, never bus traffic
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         data_ff <= TWS_DATA_RST;
         wcol_ff <= 1'b0;
      end
      else if (wr_data)
      begin
         if (flag_ff)
         begin
            data_ff <= wdata_ff;
            wcol_ff <= 1'b0;
         end
         else
            wcol_ff <= 1'b1;
      end
   end

   // axi write channels
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         awaddr_ff  <= 8'h00;
         wdata_ff   <= 8'h00;
         wstrb0_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= TWS_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata[7:0];
            wstrb0_ff <= s_axi_wstrb[0];
         end
         if (do_wr)
         begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= (wsel == TWS_SEL_NONE) ? TWS_RESP_SLVERR : TWS_RESP_OKAY;
         end
         else if (s_axi_bready)
            bvalid_ff <= 1'b0;
      end
   end

   assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
   assign s_axi_wready  = ~w_hold_ff & ~bvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;

   // axi read channel; reads have no side effects
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= TWS_RESP_OKAY;
      end
      else if (s_axi_arvalid && !rvalid_ff)
      begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= TWS_RESP_OKAY;
         case (reg_sel(s_axi_araddr))
            TWS_SEL_ADDR_CFG: rdata_ff <= {24'h000000, addr_cfg_ff};
            TWS_SEL_CTRL:     rdata_ff <= {24'h000000, flag_ff, ack_en_ff, start_req_ff,
                                           stop_req_ff, wcol_ff, if_en_ff, 1'b0, irq_en_ff};
            TWS_SEL_STATUS:   rdata_ff <= {24'h000000, status_rd};
            TWS_SEL_DATA:     rdata_ff <= {24'h000000, data_ff};
            default:
            begin
               rdata_ff <= 32'h0000_0000;
               rresp_ff <= TWS_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         rvalid_ff <= 1'b0;
   end

   assign s_axi_arready = ~rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign wake_req      = wake_ff;
   assign rx_select     = rx_sel_ff;
   assign start_go      = start_go_ff;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_flag_stretch: assert property (
      st_ff == TWS_TX_LOAD || st_ff == TWS_DONE |-> scl_oe)
      else $error("scl not held while waiting for software");
   a_status_idle: assert property (!flag_ff |-> status_rd == TWS_ST_NO_INFO)
      else $error("status not f8 with flag clear");
   a_read_addr: assert property (flag_set && st_ff == TWS_ADDR_ACK |=>
      flag_ff && (code_ff == TWS_ST_OWN_READ || code_ff == TWS_ST_ARB_READ))
      else $error("address ack did not report a8 or b0");
   a_arb_code: assert property (flag_set && st_ff == TWS_ADDR_ACK && arb_ff |=>
      code_ff == TWS_ST_ARB_READ)
      else $error("lost arbitration entry did not report b0");
   a_nack_code: assert property (flag_set && st_ff == TWS_TX_ACK && !ack_seen_ff |=>
      code_ff == TWS_ST_DATA_NACK && st_ff == TWS_DONE)
      else $error("nack did not give c0");
   a_last_ack: assert property (
      flag_set && st_ff == TWS_TX_ACK && ack_seen_ff && last_ff |=> code_ff == TWS_ST_LAST_ACK)
      else $error("ack after last byte did not give c8");
   a_ignore_free: assert property (st_ff == TWS_IGNORE || st_ff == TWS_DONE |-> !sda_oe)
      else $error("sda driven after last byte");
   a_isolate: assert property (st_ff == TWS_ADDR && !ack_en_ff |=> st_ff != TWS_ADDR_ACK)
      else $error("address acked with ack enable clear");
   a_sda_low_scl: assert property (
      st_ff == TWS_TX_BYTE && $changed(shift_ff) |-> !scl_s_ff)
      else $error("data changed while scl high");
   a_wake_raise: assert property (sleep_deep && st_ff == TWS_ADDR_ACK |=> wake_req)
      else $error("no wake request on address in sleep");
   a_start_free: assert property (start_go |-> !$past(busy_ff))
      else $error("start issued on busy bus");

   c_read_addr: cover property (flag_set && st_ff == TWS_ADDR_ACK);
   c_byte_ack:  cover property (st_ff == TWS_TX_ACK ##1 code_ff == TWS_ST_DATA_ACK && flag_ff);
   c_last_nack: cover property (st_ff == TWS_DONE && code_ff == TWS_ST_DATA_NACK);
   c_wake:      cover property ($rose(wake_req));

endmodule : tws_slave_tx
